// file: irq_enable_priority_slice.sv
`timescale 1ns/1ps

module irq_enable_priority_slice #(
   parameter bit HAS_CAN = 1'b1,
   parameter int ADDR_W  = 32
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              clkEn,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   input  wire logic              canEventReq,
   input  wire logic              canRxReadyReq,
   input  wire logic              serialPort2EventReq,
   input  wire logic              serialPort2ErrorReq,
   input  wire logic              quadDecoder2Req,
   input  wire logic              pwmSecondaryEventReq,
   output logic                   canEventIrq,
   output logic                   canRxReadyIrq,
   output logic                   serialPort2EventIrq,
   output logic                   serialPort2ErrorIrq,
   output logic                   quadDecoder2Irq,
   output logic [2:0]             quadDecoder2Level,
   output logic                   pwmSecondaryEventIrq,
   output logic [2:0]             pwmSecondaryEventLevel
);

   if (ADDR_W < 3) begin : g_bad_addr
      $error("irq_enable_priority_slice: ADDR_W must be at least 3");
   end

   typedef struct packed {
      logic [3:0]                        enable;
      logic [2:0]                        qeiPrio;
      logic [2:0]                        pwmPrio;
      logic                              wrPend;
      irq_slice_pkg::regSel_e            sel;
      logic [31:0]                       rdata;
      logic [3:0]                        irq;
      logic [1:0]                        prioIrq;
      logic [1:0][2:0]                   prioLvl;
   } state_s;

   localparam state_s ST_RESET = '{
      enable:  irq_slice_pkg::ENABLE_RESET,
      qeiPrio: irq_slice_pkg::PRIO_RESET,
      pwmPrio: irq_slice_pkg::PRIO_RESET,
      wrPend:  1'b0,
      sel:     irq_slice_pkg::SEL_NONE,
      rdata:   32'h0000_0000,
      irq:     4'h0,
      prioIrq: 2'h0,
      prioLvl: 6'h00
   };

   localparam logic [3:0] EN_MASK =
      HAS_CAN ? irq_slice_pkg::FULL_EN_MASK : irq_slice_pkg::NO_CAN_EN_MASK;

   logic [1:0]      rstPipe;
   logic            rstSync;
   state_s          st;
   state_s          nxt;
   logic [3:0]      srcReq;
   logic [1:0]      prioSrc;
   logic [1:0][2:0] prioFld;
   logic [1:0][2:0] prioLvl;
   logic [1:0]      prioGrant;

   // Word-aligned decode; everything else answers zero
   function automatic irq_slice_pkg::regSel_e regSel(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(irq_slice_pkg::ENABLE_OFS)) begin
         return irq_slice_pkg::SEL_ENABLE;
      end
      if (a == ADDR_W'(irq_slice_pkg::PRIORITY_OFS)) begin
         return irq_slice_pkg::SEL_PRIORITY;
      end
      return irq_slice_pkg::SEL_NONE;
   endfunction : regSel

   function automatic logic [31:0] readBack(input irq_slice_pkg::regSel_e s,
                                            input state_s v);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (s)
         irq_slice_pkg::SEL_ENABLE: begin
            r[3:0] = v.enable;
         end
         irq_slice_pkg::SEL_PRIORITY: begin
            r[irq_slice_pkg::QEI_PRIO_LSB +: 3] = v.qeiPrio;
            r[irq_slice_pkg::PWM_PRIO_LSB +: 3] = v.pwmPrio;
         end
         irq_slice_pkg::SEL_NONE: begin
            r = 32'h0000_0000;
         end
         default: begin
            r = 32'h0000_0000;
         end
      endcase
      return r & irq_slice_pkg::READ_MASK;
   endfunction : readBack

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'b00;
      end else if (clkEn) begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync = rstPipe[1];

   assign srcReq  = {canEventReq, canRxReadyReq, serialPort2EventReq, serialPort2ErrorReq};
   assign prioSrc = {quadDecoder2Req, pwmSecondaryEventReq};
   assign prioFld = {st.qeiPrio, st.pwmPrio};

   for (genvar i = 0; i < irq_slice_pkg::PRIO_SRC_N; i++) begin : g_prio
      prio_gate #(
         .PRIO_W (irq_slice_pkg::PRIO_W)
      ) u_gate (
         .req   (prioSrc[i]),
         .prio  (prioFld[i]),
         .grant (prioGrant[i]),
         .level (prioLvl[i])
      );
   end

   always_comb begin
      nxt = st;
      if (clkEn) begin
         // Write data phase lands here
         if (st.wrPend) begin
            unique case (st.sel)
               irq_slice_pkg::SEL_ENABLE: begin
                  nxt.enable = hwdata[3:0] & EN_MASK;
               end
               irq_slice_pkg::SEL_PRIORITY: begin
                  nxt.qeiPrio = hwdata[irq_slice_pkg::QEI_PRIO_LSB +: 3];
                  nxt.pwmPrio = hwdata[irq_slice_pkg::PWM_PRIO_LSB +: 3];
               end
               irq_slice_pkg::SEL_NONE: begin
                  nxt.wrPend = 1'b0;
               end
               default: begin
                  nxt.wrPend = 1'b0;
               end
            endcase
         end
         nxt.wrPend = 1'b0;
         nxt.sel    = irq_slice_pkg::SEL_NONE;
         if (hsel && hready && htrans[1]) begin
            nxt.sel    = regSel(haddr);
            nxt.wrPend = hwrite;
            // Read sees a write finishing in the same cycle
            nxt.rdata  = hwrite ? 32'h0000_0000 : readBack(regSel(haddr), nxt);
         end
         nxt.irq     = srcReq & st.enable;
         nxt.prioIrq = prioGrant;
         nxt.prioLvl = prioLvl;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         st <= ST_RESET;
      end else begin
         st <= nxt;
      end
   end

   assign hreadyout              = clkEn;
   assign hresp                  = 1'b0;
   assign hrdata                 = st.rdata;
   assign canEventIrq            = st.irq[irq_slice_pkg::CAN_EVENT_BIT];
   assign canRxReadyIrq          = st.irq[irq_slice_pkg::CAN_RX_BIT];
   assign serialPort2EventIrq    = st.irq[irq_slice_pkg::SP2_EVENT_BIT];
   assign serialPort2ErrorIrq    = st.irq[irq_slice_pkg::SP2_ERROR_BIT];
   assign quadDecoder2Irq        = st.prioIrq[1];
   assign quadDecoder2Level      = st.prioLvl[1];
   assign pwmSecondaryEventIrq   = st.prioIrq[0];
   assign pwmSecondaryEventLevel = st.prioLvl[0];

   // A frozen cycle holds the outputs, so only freshly updated ones are traced back
   chk_can_event_gate: assert property (@(posedge core_clk) disable iff (!rstSync)
      canEventIrq && $past(clkEn) |-> $past(canEventReq) && $past(st.enable[3]))
      else $error("CAN event irq without enabled request");

   chk_can_rx_gate: assert property (@(posedge core_clk) disable iff (!rstSync)
      (clkEn && canRxReadyReq && st.enable[2]) |=> canRxReadyIrq)
      else $error("CAN rx ready request not passed");

   chk_sp2_event_gate: assert property (@(posedge core_clk) disable iff (!rstSync)
      (clkEn && serialPort2EventReq && st.enable[1]) |=> serialPort2EventIrq)
      else $error("Serial port 2 event request not passed");

   chk_enable_blocks: assert property (@(posedge core_clk) disable iff (!rstSync)
      (clkEn && !st.enable[0]) |=> !serialPort2ErrorIrq)
      else $error("Disabled request reached arbitration");

   chk_no_can_enables: assert property (@(posedge core_clk) disable iff (!rstSync)
      HAS_CAN || (st.enable[3:2] == 2'b00 && !canEventIrq && !canRxReadyIrq))
      else $error("CAN enable set on a part without CAN");

   chk_qei_prio_write: assert property (@(posedge core_clk) disable iff (!rstSync)
      (clkEn && st.wrPend && st.sel == irq_slice_pkg::SEL_PRIORITY)
      |=> st.qeiPrio == $past(hwdata[14:12]))
      else $error("Quadrature priority field not written");

   chk_level_follows: assert property (@(posedge core_clk) disable iff (!rstSync)
      pwmSecondaryEventIrq && $past(clkEn) |-> pwmSecondaryEventLevel == $past(st.pwmPrio)
                             && pwmSecondaryEventLevel != 3'h0)
      else $error("PWM secondary level differs from its field");

   chk_zero_prio_off: assert property (@(posedge core_clk) disable iff (!rstSync)
      (clkEn && st.qeiPrio == 3'h0) |=> !quadDecoder2Irq && quadDecoder2Level == 3'h0)
      else $error("Zero priority source took part in arbitration");

   chk_reset_values: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rstSync) |-> st.qeiPrio == 3'h4 && st.pwmPrio == 3'h4 && st.enable == 4'h0)
      else $error("Wrong values after reset");

   chk_unused_zero: assert property (@(posedge core_clk) disable iff (!rstSync)
      (hrdata & ~irq_slice_pkg::READ_MASK) == 32'h0000_0000)
      else $error("Unimplemented bit read as one");

endmodule : irq_enable_priority_slice

// file: irq_enable_priority_slice_bench.sv
`timescale 1ns/1ps

module irq_enable_priority_slice_bench;
   typedef struct packed {
      logic [3:0] en;
      logic [2:0] qp;
      logic [2:0] pp;
      logic [5:0] req;
      logic [5:0] irq;
      logic [2:0] ql;
      logic [2:0] pl;
   } row_s;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b1;
   logic        clkEn    = 1'b1;
   logic        hsel     = 1'b0;
   logic [31:0] haddr    = 32'h0;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [2:0]  hsize    = 3'h2;
   logic [31:0] hwdata   = 32'h0;
   logic [5:0]  reqSet   = 6'h00;
   logic        hready, hreadyNc, hresp, hrespNc;
   logic [31:0] hrdata, hrdataNc, rd, rdNc;
   logic [5:0]  req, irq, irqNc;
   logic [2:0]  qLvl, pLvl, qLvlNc, pLvlNc;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          cycles     = 0;
   // Request and irq order: can event, can rx, port2 event, port2 error, quad, pwm
   row_s rows [6] = '{
      '{4'hF, 3'h7, 3'h1, 6'h3F, 6'h3F, 3'h7, 3'h1},
      '{4'h0, 3'h0, 3'h0, 6'h3F, 6'h00, 3'h0, 3'h0},
      '{4'h8, 3'h3, 3'h5, 6'h3F, 6'h23, 3'h3, 3'h5},
      '{4'h4, 3'h2, 3'h6, 6'h2A, 6'h02, 3'h2, 3'h0},
      '{4'h2, 3'h0, 3'h4, 6'h3F, 6'h09, 3'h0, 3'h4},
      '{4'h1, 3'h1, 3'h7, 6'h3F, 6'h07, 3'h1, 3'h7}};

   always #20 core_clk = ~core_clk;

   irq_source_model src_u (.core_clk(core_clk), .reqSet(reqSet), .req(req));

   irq_enable_priority_slice dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .canEventReq(req[5]), .canRxReadyReq(req[4]), .serialPort2EventReq(req[3]),
      .serialPort2ErrorReq(req[2]), .quadDecoder2Req(req[1]), .pwmSecondaryEventReq(req[0]),
      .canEventIrq(irq[5]), .canRxReadyIrq(irq[4]), .serialPort2EventIrq(irq[3]),
      .serialPort2ErrorIrq(irq[2]), .quadDecoder2Irq(irq[1]), .quadDecoder2Level(qLvl),
      .pwmSecondaryEventIrq(irq[0]), .pwmSecondaryEventLevel(pLvl));

   irq_enable_priority_slice #(.HAS_CAN(1'b0)) dut_nocan_u (
      .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyNc), .hrdata(hrdataNc), .hresp(hrespNc),
      .canEventReq(req[5]), .canRxReadyReq(req[4]), .serialPort2EventReq(req[3]),
      .serialPort2ErrorReq(req[2]), .quadDecoder2Req(req[1]), .pwmSecondaryEventReq(req[0]),
      .canEventIrq(irqNc[5]), .canRxReadyIrq(irqNc[4]), .serialPort2EventIrq(irqNc[3]),
      .serialPort2ErrorIrq(irqNc[2]), .quadDecoder2Irq(irqNc[1]), .quadDecoder2Level(qLvlNc),
      .pwmSecondaryEventIrq(irqNc[0]), .pwmSecondaryEventLevel(pLvlNc));

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // Entered just after an edge; one single-word transfer, read data kept in rd and rdNc
   task automatic busOp(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      hsel   <= 1'b1;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd   = hrdata;
      rdNc = hrdataNc;
   endtask : busOp

   task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmpReg

   task automatic cmpOut(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmpOut

   initial begin
      // Scheduled so the design sees a real falling edge of reset at start
      rst_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      foreach (rows[i]) begin
         busOp(1'b1, 32'h00, 32'hFFFF_FFF0 | 32'(rows[i].en));
         busOp(1'b1, 32'h04, 32'hFFFF_8F8F | (32'(rows[i].qp) << 12) | (32'(rows[i].pp) << 4));
         reqSet <= rows[i].req;
         busOp(1'b0, 32'h00, 32'h0);
         cmpReg(rd, 32'(rows[i].en));
         cmpReg(rdNc, 32'(rows[i].en & 4'h3));
         busOp(1'b0, 32'h04, 32'h0);
         cmpReg(rd, (32'(rows[i].qp) << 12) | (32'(rows[i].pp) << 4));
         cmpOut({irq, qLvl, pLvl}, {rows[i].irq, rows[i].ql, rows[i].pl});
         cmpOut({irqNc, qLvlNc, pLvlNc}, {rows[i].irq & 6'h0F, rows[i].ql, rows[i].pl});
         $display("row %0d done", i);
      end
      rst_n  <= 1'b0;
      reqSet <= 6'h3F;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      cmpOut({irq, qLvl, pLvl}, {6'h03, 3'h4, 3'h4});
      busOp(1'b0, 32'h00, 32'h0);
      cmpReg(rd, 32'h0000_0000);
      busOp(1'b0, 32'h04, 32'h0);
      cmpReg(rd, 32'h0000_4040);
      $display("reset test done");
      busOp(1'b1, 32'h08, 32'hFFFF_FFFF);
      busOp(1'b0, 32'h08, 32'h0);
      cmpReg(rd, 32'h0000_0000);
      cmpReg(32'({hresp, hrespNc}), 32'h0000_0000);
      busOp(1'b0, 32'h00, 32'h0);
      cmpReg(rd, 32'h0000_0000);
      busOp(1'b0, 32'h04, 32'h0);
      cmpReg(rd, 32'h0000_4040);
      $display("unmapped test done");
      // Clock enable low in a read data phase: state and outputs freeze, bus stalls
      busOp(1'b1, 32'h00, 32'h0000_000F);
      fork
         busOp(1'b0, 32'h00, 32'h0);
         begin
            @(posedge core_clk);
            clkEn  <= 1'b0;
            reqSet <= 6'h00;
            repeat (2) @(posedge core_clk);
            cmpOut({irq, qLvl, pLvl}, {6'h3F, 3'h4, 3'h4});
            cmpOut({irqNc, qLvlNc, pLvlNc}, {6'h0F, 3'h4, 3'h4});
            cmpReg(32'({hready, hreadyNc}), 32'h0000_0000);
            @(posedge core_clk);
            clkEn <= 1'b1;
         end
      join
      cmpReg(rd, 32'h0000_000F);
      cmpReg(rdNc, 32'h0000_0003);
      @(posedge core_clk);
      cmpOut({irq, qLvl, pLvl}, {6'h00, 3'h0, 3'h0});
      $display("stall test done");
      give_verdict();
   end
endmodule : irq_enable_priority_slice_bench

// file: irq_slice_pkg.sv
package irq_slice_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0]  ENABLE_OFS      = 8'h00;
   localparam logic [7:0]  PRIORITY_OFS    = 8'h04;

   localparam int          REG_W           = 16;
   localparam int          PRIO_W          = 3;
   localparam int          SRC_N           = 4;
   localparam int          PRIO_SRC_N      = 2;

   // Enable register bit positions
   localparam int          CAN_EVENT_BIT   = 3;
   localparam int          CAN_RX_BIT      = 2;
   localparam int          SP2_EVENT_BIT   = 1;
   localparam int          SP2_ERROR_BIT   = 0;

   // Priority register field positions
   localparam int          QEI_PRIO_LSB    = 12;
   localparam int          PWM_PRIO_LSB    = 4;

   // Reset values, and the priority value that switches a source off
   localparam logic [3:0]  ENABLE_RESET    = 4'h0;
   localparam logic [2:0]  PRIO_RESET      = 3'h4;
   localparam logic [2:0]  PRIO_OFF        = 3'h0;

   // Enable bits that survive a write when no CAN controller is fitted, and when one is
   localparam logic [3:0]  NO_CAN_EN_MASK  = 4'h3;
   localparam logic [3:0]  FULL_EN_MASK    = 4'hF;

   // Bits that can ever read as one
   localparam logic [31:0] READ_MASK       = 32'h0000_707F;

   typedef enum logic [1:0] {
      SEL_NONE     = 2'b00,
      SEL_ENABLE   = 2'b01,
      SEL_PRIORITY = 2'b10
   } regSel_e;

endpackage : irq_slice_pkg

// file: irq_source_model.sv
`timescale 1ns/1ps

module irq_source_model (
   input  wire logic       core_clk,
   input  wire logic [5:0] reqSet,
   output logic      [5:0] req
);
   // Requests move just after an edge, like same-clock peripheral logic
   always @(posedge core_clk) begin
      req <= reqSet;
   end
endmodule : irq_source_model

// file: prio_gate.sv
`timescale 1ns/1ps

module prio_gate #(
   parameter int PRIO_W = 3
) (
   input  wire logic              req,
   input  wire logic [PRIO_W-1:0] prio,
   output logic                   grant,
   output logic      [PRIO_W-1:0] level
);

   if (PRIO_W < 1) begin : g_bad_width
      $error("prio_gate: PRIO_W must be at least 1");
   end

   // A zero field removes the source from arbitration altogether
   always_comb begin
      grant = req && (prio != '0);
      level = grant ? prio : '0;
   end

endmodule : prio_gate
